// file: compare_skip_less_exec.sv
// What this block does
// RQ1: Recognise word with top seven bits 0110000; bit 8 selects bank, low byte addresses.
// RQ2: Unsigned compare of memory byte against working register; skip only if strictly less.
// RQ3: On skip, discard the fetched next instruction; run an all-idle cycle instead.
// RQ4: One word; one cycle without skip, two with skip, three skipping a two-word.
// RQ5: Selector 0 uses the fixed access bank; selector 1 uses the bank select register.
// RQ6: Skipping a two-word instruction inserts two consecutive idle cycles before fetch resumes.
// RQ7: Working register, memory byte and status flags stay unchanged; only program flow moves.
`include "compare_skip_cfg.svh"
`default_nettype none

module compare_skip_less_exec (
  input  wire logic        ref_clk,
  input  wire logic        reset,
  input  wire logic [15:0] instr_word,
  input  wire logic        next_two_word,
  input  wire logic [7:0]  working_register,
  input  wire logic [3:0]  bank_select_register,
  input  wire logic [7:0]  mem_rdata,
  output logic [1:0]       phase,
  output logic             cycle_start,
  output logic             op_active,
  output logic [11:0]      mem_addr,
  output logic             mem_rd,
  output logic             skip_taken,
  output logic             discard_fetch,
  output logic             nop_active,
  output logic             fetch_resume,
  output logic             work_we,
  output logic             mem_we,
  output logic             status_we
);

  compare_skip_pkg::phase_t      phase_q;
  compare_skip_pkg::exec_state_t state_q;
  logic                          op_q;
  logic                          sel_q;
  logic [11:0]                   addr_q;
  logic [7:0]                    mem_byte_q;
  logic [7:0]                    work_q;
  logic                          skip_q;
  logic                          two_q;
  logic                          match;
  logic [7:0]                    f_field;
  logic [11:0]                   addr_d;

  compare_if cmp ();

  compare_unit u_compare (
    .cmp (cmp.unit)
  );

  // Phase counter: four clocks make one instruction cycle
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      phase_q <= `CSL_PHASE_Q1;
    else
      phase_q <= phase_q + 2'h1;
  end

  // Pattern match on the opcode field only; other bits are operands
  assign match   = instr_word[`CSL_OPC_MSB:`CSL_OPC_LSB] == `CSL_OPC_VALUE; // RQ1
  assign f_field = instr_word[`CSL_ADDR_MSB:0];

  // Operand address: access bank splits low and high, else bank select on top
  always_comb
  begin
    addr_d = {bank_select_register, f_field}; // RQ5
    if (!instr_word[`CSL_SEL_BIT])
    begin
      if (f_field < `CSL_ACCESS_SPLIT)
        addr_d = {`CSL_ACCESS_LO_BANK, f_field}; // RQ5
      else
        addr_d = {`CSL_ACCESS_HI_BANK, f_field}; // RQ5
    end
  end

  // Decode at Q1; idle cycles never decode since the fetched word is stale
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      op_q  <= 1'b0;
      sel_q <= 1'b0;
    end
    else if (phase_q == `CSL_PHASE_Q1)
    begin
      op_q  <= match && (state_q == compare_skip_pkg::ST_EXEC); // RQ1 RQ3
      sel_q <= instr_word[`CSL_SEL_BIT];
    end
  end

  // Address latched at decode so it is stable through the read phase
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      addr_q <= `CSL_RST_ADDR;
    else if (phase_q == `CSL_PHASE_Q1 && state_q == compare_skip_pkg::ST_EXEC && match)
      addr_q <= addr_d; // RQ5
  end

  // Operand capture at Q2; the read is combinational from the memory side
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      mem_byte_q <= `CSL_RST_BYTE;
      work_q     <= `CSL_RST_BYTE;
    end
    else if (mem_rd)
    begin
      mem_byte_q <= mem_rdata;
      work_q     <= working_register;
    end
  end

  assign cmp.mem_byte  = mem_byte_q;
  assign cmp.work_byte = work_q;

  // Skip decision at Q3; cleared at each decode so it never leaks to the next word
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      skip_q <= 1'b0;
    else if (phase_q == `CSL_PHASE_Q1)
      skip_q <= 1'b0;
    else if (phase_q == `CSL_PHASE_Q3 && op_q)
      skip_q <= cmp.less; // RQ2
  end

  // Length of the following word is taken when the skip is committed
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      two_q <= 1'b0;
    else if (discard_fetch)
      two_q <= next_two_word; // RQ6
  end

  // Sequencer moves only at the end of Q4 so idle cycles stay whole
  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      state_q <= compare_skip_pkg::ST_EXEC;
    else if (phase_q == `CSL_PHASE_Q4)
    begin
      unique case (state_q)
        compare_skip_pkg::ST_EXEC:
        begin
          if (discard_fetch)
            state_q <= compare_skip_pkg::ST_NOP1; // RQ3 RQ4
        end
        compare_skip_pkg::ST_NOP1:
        begin
          if (two_q)
            state_q <= compare_skip_pkg::ST_NOP2; // RQ6
          else
            state_q <= compare_skip_pkg::ST_EXEC; // RQ4
        end
        compare_skip_pkg::ST_NOP2:
          state_q <= compare_skip_pkg::ST_EXEC; // RQ6
        default:
          state_q <= compare_skip_pkg::ST_EXEC;
      endcase
    end
  end

  // Handshake outputs; the fetch unit honours discard and resume itself
  assign phase         = phase_q;
  assign cycle_start   = phase_q == `CSL_PHASE_Q1;
  assign op_active     = op_q;
  assign mem_addr      = addr_q;
  assign mem_rd        = op_q && phase_q == `CSL_PHASE_Q2;
  assign skip_taken    = skip_q;
  assign discard_fetch = op_q && skip_q && phase_q == `CSL_PHASE_Q4; // RQ3
  assign nop_active    = state_q != compare_skip_pkg::ST_EXEC; // RQ3
  assign fetch_resume  = phase_q == `CSL_PHASE_Q4 &&
                         ((state_q == compare_skip_pkg::ST_NOP1 && !two_q) ||
                          state_q == compare_skip_pkg::ST_NOP2); // RQ6

  // Never writes anything: no destination and no status update
  assign work_we   = 1'b0; // RQ7
  assign mem_we    = 1'b0; // RQ7
  assign status_we = 1'b0; // RQ7

  // Checks next to the logic
  sequence s_idle_cycle;
    nop_active [*4];
  endsequence

  sequence s_back_to_exec;
    !nop_active && cycle_start;
  endsequence

  property p_decode;
    @(posedge ref_clk) disable iff (reset)
    (cycle_start && !nop_active && match) |=> (op_q && mem_rd);
  endproperty
  a_decode: assert property (p_decode) else $error("pattern not decoded"); // RQ1

  property p_no_false_decode;
    @(posedge ref_clk) disable iff (reset)
    (cycle_start && !match) |=> !op_q [*4];
  endproperty
  a_no_false_decode: assert property (p_no_false_decode) else $error("false decode"); // RQ1

  property p_compare;
    @(posedge ref_clk) disable iff (reset)
    (op_q && phase_q == `CSL_PHASE_Q4) |-> (skip_q == (mem_byte_q < work_q));
  endproperty
  a_compare: assert property (p_compare) else $error("wrong skip decision"); // RQ2

  property p_skip_idle;
    @(posedge ref_clk) disable iff (reset)
    discard_fetch |=> s_idle_cycle and (!mem_rd [*4]);
  endproperty
  a_skip_idle: assert property (p_skip_idle) else $error("idle cycle not inserted"); // RQ3

  property p_no_skip_len;
    @(posedge ref_clk) disable iff (reset)
    (op_q && phase_q == `CSL_PHASE_Q4 && !skip_q) |=> s_back_to_exec;
  endproperty
  a_no_skip_len: assert property (p_no_skip_len) else $error("one cycle expected"); // RQ4

  property p_skip_len;
    @(posedge ref_clk) disable iff (reset)
    (discard_fetch && !next_two_word) |=> s_idle_cycle ##1 s_back_to_exec;
  endproperty
  a_skip_len: assert property (p_skip_len) else $error("two cycles expected"); // RQ4

  property p_bank;
    @(posedge ref_clk) disable iff (reset)
    mem_rd |-> (sel_q ? (mem_addr[11:8] == $past(bank_select_register, 1))
                      : (mem_addr[11:8] == (mem_addr[7] ? `CSL_ACCESS_HI_BANK
                                                         : `CSL_ACCESS_LO_BANK)));
  endproperty
  a_bank: assert property (p_bank) else $error("wrong operand bank"); // RQ5

  property p_two_word;
    @(posedge ref_clk) disable iff (reset)
    (discard_fetch && next_two_word) |=> s_idle_cycle ##1 s_idle_cycle ##1 s_back_to_exec;
  endproperty
  a_two_word: assert property (p_two_word) else $error("two idle cycles expected"); // RQ6

  property p_no_write;
    @(posedge ref_clk) disable iff (reset)
    (op_q || nop_active) |-> !(work_we || mem_we || status_we);
  endproperty
  a_no_write: assert property (p_no_write) else $error("unexpected write"); // RQ7

endmodule : compare_skip_less_exec

`default_nettype wire

// file: compare_skip_cfg.svh
`ifndef COMPARE_SKIP_CFG_SVH
`define COMPARE_SKIP_CFG_SVH

// Instruction field layout of the compare-skip-if-less word
`define CSL_OPC_MSB        15
`define CSL_OPC_LSB        9
`define CSL_OPC_VALUE      7'h30
`define CSL_SEL_BIT        8
`define CSL_ADDR_MSB       7

// Phase codes inside one instruction cycle
`define CSL_PHASE_Q1       2'h0
`define CSL_PHASE_Q2       2'h1
`define CSL_PHASE_Q3       2'h2
`define CSL_PHASE_Q4       2'h3

// Fixed access bank mapping
`define CSL_ACCESS_SPLIT   8'h80
`define CSL_ACCESS_LO_BANK 4'h0
`define CSL_ACCESS_HI_BANK 4'hF

// Reset values
`define CSL_RST_WORD       16'h0000
`define CSL_RST_BYTE       8'h00
`define CSL_RST_ADDR       12'h000

// Instruction cycle counts and clocks per cycle
`define CSL_CYC_NOSKIP     1
`define CSL_CYC_SKIP       2
`define CSL_CYC_SKIP_2W    3
`define CSL_CLK_PER_CYC    4

`endif

// file: compare_skip_pkg.sv
`default_nettype none

package compare_skip_pkg;

  // Execution state, Gray coded along exec -> nop -> second nop
  typedef enum logic [1:0] {
    ST_EXEC = 2'h0,
    ST_NOP1 = 2'h1,
    ST_NOP2 = 2'h3
  } exec_state_t;

  typedef logic [1:0] phase_t;

endpackage : compare_skip_pkg

`default_nettype wire

// file: compare_if.sv
`default_nettype none

// Carries the operands and result between the sequencer and the comparator
interface compare_if;
  logic [7:0] mem_byte;
  logic [7:0] work_byte;
  logic [8:0] diff;
  logic       less;

  modport seq  (output mem_byte, output work_byte, input diff, input less);
  modport unit (input mem_byte, input work_byte, output diff, output less);
endinterface : compare_if

`default_nettype wire

// file: compare_unit.sv
`default_nettype none

// Unsigned subtract; a borrow out means the memory byte is below the working register
module compare_unit (
  compare_if.unit cmp
);

  // Nine-bit difference keeps the borrow in the top bit
  assign cmp.diff = {1'b0, cmp.mem_byte} - {1'b0, cmp.work_byte};
  assign cmp.less = cmp.diff[8]; // RQ2

endmodule : compare_unit

`default_nettype wire

// file: tb_compare_skip_less_exec.sv
`default_nettype none

module tb_compare_skip_less_exec;
  timeunit 1ns;
  timeprecision 1ns;

  logic        ref_clk;
  logic        reset;
  logic [15:0] instr_word;
  logic        next_two_word;
  logic [7:0]  working_register;
  logic [3:0]  bank_select_register;
  logic [7:0]  mem_rdata;
  logic [1:0]  phase;
  logic        cycle_start;
  logic        op_active;
  logic [11:0] mem_addr;
  logic        mem_rd;
  logic        skip_taken;
  logic        discard_fetch;
  logic        nop_active;
  logic        fetch_resume;
  logic        work_we;
  logic        mem_we;
  logic        status_we;
  int          n_errors;
  int          checks_done;
  int          seed;
  logic [15:0] w;
  logic [31:0] r;

  compare_skip_less_exec DUT (
    .ref_clk(ref_clk), .reset(reset), .instr_word(instr_word),
    .next_two_word(next_two_word), .working_register(working_register),
    .bank_select_register(bank_select_register), .mem_rdata(mem_rdata),
    .phase(phase), .cycle_start(cycle_start), .op_active(op_active),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .skip_taken(skip_taken),
    .discard_fetch(discard_fetch), .nop_active(nop_active),
    .fetch_resume(fetch_resume), .work_we(work_we), .mem_we(mem_we),
    .status_we(status_we)
  );

  // Free running clock, 50 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic close_out;
    $display("errors=%0d checks=%0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Operand address: selector clear splits the access bank at 0x80
  function automatic logic [11:0] addr_of(input logic [15:0] iw, input logic [3:0] b);
    if (iw[8])
      return {b, iw[7:0]};
    return {(iw[7] ? 4'hF : 4'h0), iw[7:0]};
  endfunction : addr_of

  // Nothing may ever be written back, whatever is decoded
  always @(negedge ref_clk)
    if (!reset) chk({13'h0000, work_we, mem_we, status_we}, 16'h0000);

  // One instruction: wait for a decodable Q1, drive, then follow it to the end
  task automatic do_op(input logic [15:0] iw, input logic [7:0] wr, input logic [3:0] b,
                       input logic [7:0] m, input logic two);
    logic hit;
    logic sk;
    int   i;
    int   n;
    hit = (iw[15:9] === 7'h30);
    sk  = hit && (m < wr);
    n   = 0;
    i   = 0;
    while (!(phase === 2'h3 && discard_fetch !== 1'b1 &&
             (nop_active !== 1'b1 || fetch_resume === 1'b1)))
    begin
      @(negedge ref_clk);
      i++;
      if (i > 40)
      begin
        n_errors++;
        close_out();
      end
    end
    @(posedge ref_clk);
    instr_word           <= iw;
    working_register     <= wr;
    bank_select_register <= b;
    mem_rdata            <= m;
    next_two_word        <= two;
    @(posedge ref_clk);
    instr_word <= 16'h0000;
    @(negedge ref_clk);
    chk({15'h0000, op_active}, {15'h0000, hit});
    chk({15'h0000, mem_rd}, {15'h0000, hit});
    chk({14'h0000, phase}, 16'h0001);
    if (hit) chk({4'h0, mem_addr}, {4'h0, addr_of(iw, b)});
    repeat (2) @(negedge ref_clk);
    chk({15'h0000, skip_taken}, {15'h0000, sk});
    chk({15'h0000, discard_fetch}, {15'h0000, sk});
    if (sk)
    begin
      // A matching word sits in decode through the idle cycles to prove it is dropped
      @(posedge ref_clk);
      instr_word <= 16'h61AA;
      for (i = 0; i < 12; i++)
      begin
        @(negedge ref_clk);
        if (nop_active === 1'b1) n++;
        if (n > 1) chk({15'h0000, op_active}, 16'h0000);
        if (fetch_resume === 1'b1) break;
      end
      chk({15'h0000, fetch_resume}, 16'h0001);
      chk(16'(n), two ? 16'h0008 : 16'h0004);
    end
  endtask : do_op

  // Reset, corner cases, then seeded random traffic
  initial
  begin
    seed                 = 32'h2761;
    n_errors             = 0;
    checks_done          = 0;
    reset                = 1'b1;
    instr_word           = 16'h0000;
    next_two_word        = 1'b0;
    working_register     = 8'h00;
    bank_select_register = 4'h0;
    mem_rdata            = 8'h00;
    repeat (5) @(posedge ref_clk);
    chk({14'h0000, cycle_start, nop_active}, 16'h0002);
    reset <= 1'b0;
    do_op(16'h6080, 8'h10, 4'h5, 8'h10, 1'b0);
    do_op(16'h617F, 8'h10, 4'h5, 8'h0F, 1'b0);
    do_op(16'h607F, 8'hFF, 4'h5, 8'h00, 1'b1);
    do_op(16'h6080, 8'h00, 4'hA, 8'hFF, 1'b0);
    do_op(16'h6200, 8'hFF, 4'h0, 8'h00, 1'b0);
    do_op(16'h6400, 8'hFF, 4'h0, 8'h00, 1'b1);
    do_op(16'h61FF, 8'h01, 4'hF, 8'h00, 1'b0);
    do_op(16'h6100, 8'h01, 4'h3, 8'h00, 1'b1);
    repeat (60)
    begin
      // Bias half the words onto the opcode so skips stay frequent
      w = 16'($random(seed));
      r = $random(seed);
      if (r[31]) w[15:9] = 7'h30;
      do_op(w, r[7:0], r[11:8], r[19:12], r[20]);
    end
    close_out();
  end
endmodule : tb_compare_skip_less_exec

`default_nettype wire
